// File: src/guard_pkg.sv
/*
 * Constants, types and address map of the mode and access guard.
 * Assumes a 16-bit core address bus and a 16-bit software register port.
 */
`default_nettype none
package guard_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int RADDR_W = 4;

	// ****************************************************************
	// Modes, ranked by code value
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_USER = 2'h0,
		MODE_SYS = 2'h1,
		MODE_BOOT = 2'h3
	} mode_type;

	// ****************************************************************
	// Segment rights
	// ****************************************************************
	typedef enum logic [1:0] {
		RIGHT_NONE = 2'h0,
		RIGHT_COND = 2'h1,
		RIGHT_FULL = 2'h2
	} right_type;

	// Core access request
	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic apar;
	} acc_req_type;

	// ****************************************************************
	// Address map: top two bits select ROM, NVM, RAM, upper
	// ****************************************************************
	localparam logic [1:0] SEG_ROM = 2'h0;
	localparam logic [1:0] SEG_NVM = 2'h1;
	localparam logic [1:0] SEG_RAM = 2'h2;
	localparam logic [1:0] SEG_UP = 2'h3;
	localparam logic [13:0] ROM_LIMIT = 14'h3000;
	localparam logic [13:0] NVM_LIMIT = 14'h3F00;
	localparam logic [13:0] RAM_LIMIT = 14'h0800;
	localparam logic [13:0] SHARED_LIMIT = 14'h3000;
	localparam logic [7:0] CR_PAGE = 8'hF0;
	localparam logic [7:0] CR_COUNT = 8'h20;
	localparam logic [7:0] CR_USER_RD = 8'h08;
	localparam logic [7:0] CR_USER_WR = 8'h04;
	localparam logic [7:0] CR_FUSE_BASE = 8'h18;

	// ****************************************************************
	// Software register offsets and reset values
	// ****************************************************************
	localparam logic [RADDR_W-1:0] R_COND_OPEN = 4'h0;
	localparam logic [RADDR_W-1:0] R_FW_CTRL = 4'h1;
	localparam logic [RADDR_W-1:0] R_FW_LO = 4'h2;
	localparam logic [RADDR_W-1:0] R_FW_HI = 4'h3;
	localparam logic [RADDR_W-1:0] R_MODE = 4'h4;
	localparam logic [RADDR_W-1:0] R_INT_STAT = 4'h5;
	localparam logic [RADDR_W-1:0] R_INT_CLR = 4'h6;
	localparam logic [RADDR_W-1:0] R_INT_EN = 4'h7;
	localparam logic [3:0] COND_RESET = 4'h0;
	localparam logic [ADDR_W-1:0] FW_LO_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] FW_HI_RESET = 16'h0000;

	// Interrupt status bit positions
	localparam int EV_CONSIST = 0;
	localparam int EV_RANGE = 1;
	localparam int EV_SEG = 2;
	localparam int EV_CR = 3;
	localparam int EV_N = 4;

endpackage : guard_pkg
`default_nettype wire

// File: src/mode_and_access_guard.sv
/*
 * Mode control and access guard between the core and its memories.
 * Assumes fuse levels arrive asynchronously from the fuse array, the core
 * and the software register port share MCLK_I, and the reset controller
 * takes a one-cycle request with a security tag.
 */
// Notes on behaviour
// [RULE1] Conditional grants closed at boot
// [RULE2] Any error closes all conditional grants
// [RULE3] Privileged code opens, accesses, then closes grants
// [RULE4] Each segment right is full, conditional or none
// [RULE5] Firewall window checked on every user-mode access outside the control page
// [RULE6] Control registers gated by function and mode
// [RULE7] Forbidden control read ignored, security reset
// [RULE8] Access outside implemented memory forces reset
// [RULE9] Address parity checked on every access
// [RULE10] Test program if enabled, else application
// [RULE11] Delivery fuses forbid test program
// [RULE12] User mode cannot touch fuse configuration
// [RULE13] Boot above system above user
// [RULE14] Shared library visible to system and user
// [RULE15] Application settings cleared after use
// [RULE16] Violation gives tagged one-cycle reset request
`default_nettype none
module mode_and_access_guard (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_I,
	// Fuse levels, asynchronous
	input wire logic FUSE_TEST_EN_I,
	input wire logic FUSE_DELIVERED_I,
	input wire logic FUSE_APP_PRIV_I,
	// Core control
	input wire logic BOOT_DONE_I,
	input wire logic CORE_ERR_I,
	input wire logic SESSION_END_I,
	// Core access
	input wire guard_pkg::acc_req_type ACC_REQ_I,
	output logic ACC_GRANT_O,
	output logic ACC_DENY_O,
	// Software registers
	input wire logic [guard_pkg::RADDR_W-1:0] REG_ADDR_I,
	input wire logic [guard_pkg::DATA_W-1:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [guard_pkg::DATA_W-1:0] REG_RDATA_O,
	// Status and reset request
	output logic [1:0] MODE_O,
	output logic TEST_PROG_O,
	output logic RST_REQ_O,
	output logic RST_SEC_O,
	output logic IRQ_O
);

	// ****************************************************************
	// Decoding functions
	// ****************************************************************
	function automatic guard_pkg::right_type seg_right(
		input guard_pkg::mode_type m, input logic [1:0] s);
		guard_pkg::right_type r;
		r = guard_pkg::RIGHT_NONE;
		case (m)
		guard_pkg::MODE_BOOT: r = guard_pkg::RIGHT_FULL; // [RULE13]
		guard_pkg::MODE_SYS: begin
			case (s)
			guard_pkg::SEG_ROM: r = guard_pkg::RIGHT_COND;
			default: r = guard_pkg::RIGHT_FULL;
			endcase
		end
		guard_pkg::MODE_USER: begin
			case (s)
			guard_pkg::SEG_ROM: r = guard_pkg::RIGHT_NONE;
			guard_pkg::SEG_NVM: r = guard_pkg::RIGHT_COND;
			default: r = guard_pkg::RIGHT_FULL; // [RULE14]
			endcase
		end
		default: r = guard_pkg::RIGHT_NONE;
		endcase
		return r;
	endfunction : seg_right

	function automatic logic cr_allowed(input guard_pkg::mode_type m,
		input logic [7:0] idx, input logic wr);
		logic ok;
		ok = 1'b0;
		if (idx < guard_pkg::CR_COUNT) begin
			case (m)
			guard_pkg::MODE_BOOT: ok = 1'b1;
			guard_pkg::MODE_SYS: ok = !(wr && idx >= guard_pkg::CR_FUSE_BASE);
			guard_pkg::MODE_USER: ok = wr ? (idx < guard_pkg::CR_USER_WR)
				: (idx < guard_pkg::CR_USER_RD); // [RULE12]
			default: ok = 1'b0;
			endcase
		end
		return ok;
	endfunction : cr_allowed

	// ****************************************************************
	// Fuse synchronisers
	// ****************************************************************
	logic [2:0] fuse_meta_q;
	logic [2:0] fuse_q;

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			fuse_meta_q <= 3'h0;
			fuse_q <= 3'h0;
		end else begin
			fuse_meta_q <= {FUSE_APP_PRIV_I, FUSE_DELIVERED_I, FUSE_TEST_EN_I};
			fuse_q <= fuse_meta_q;
		end
	end

	wire test_ok = fuse_q[0] && !fuse_q[1]; // [RULE11]

	// ****************************************************************
	// Mode state
	// ****************************************************************
	guard_pkg::mode_type mode_q;
	guard_pkg::mode_type mode_d;
	logic test_prog_q;
	logic test_prog_d;
	wire is_user = (mode_q == guard_pkg::MODE_USER);
	wire reg_wr_ok = REG_WR_I && !is_user; // [RULE12]
	wire mode_wr = reg_wr_ok && REG_ADDR_I == guard_pkg::R_MODE;

	always_comb begin
		mode_d = mode_q;
		test_prog_d = test_prog_q;
		if (mode_q == guard_pkg::MODE_BOOT && BOOT_DONE_I) begin
			if (test_ok) begin
				mode_d = guard_pkg::MODE_SYS; // [RULE10]
				test_prog_d = 1'b1;
			end else begin
				mode_d = fuse_q[2] ? guard_pkg::MODE_SYS
					: guard_pkg::MODE_USER; // [RULE10]
			end
		end else if (mode_q == guard_pkg::MODE_SYS && mode_wr &&
			REG_WDATA_I[1:0] == guard_pkg::MODE_USER) begin
			// Privilege drops at boot completion or by software; it rises only through reset
			mode_d = guard_pkg::MODE_USER; // [RULE13]
			test_prog_d = 1'b0;
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			mode_q <= guard_pkg::MODE_BOOT; // [RULE13]
			test_prog_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			test_prog_q <= test_prog_d;
		end
	end

	// ****************************************************************
	// Access checks
	// ****************************************************************
	guard_pkg::acc_req_type req;
	assign req = ACC_REQ_I;
	logic [3:0] cond_open_q;
	logic fw_en_q;
	logic [guard_pkg::ADDR_W-1:0] fw_lo_q;
	logic [guard_pkg::ADDR_W-1:0] fw_hi_q;

	wire [1:0] seg = req.addr[15:14];
	wire [13:0] off = req.addr[13:0];
	wire is_cr = (seg == guard_pkg::SEG_UP) && (req.addr[15:8] ==
		guard_pkg::CR_PAGE);
	wire [7:0] cr_idx = req.addr[7:0];
	wire consist_bad = req.valid && (^req.addr != req.apar); // [RULE9]
	logic in_range;
	always_comb begin
		case (seg)
		guard_pkg::SEG_ROM: in_range = off < guard_pkg::ROM_LIMIT;
		guard_pkg::SEG_NVM: in_range = off < guard_pkg::NVM_LIMIT;
		guard_pkg::SEG_RAM: in_range = off < guard_pkg::RAM_LIMIT;
		default: in_range = is_cr || off < guard_pkg::SHARED_LIMIT;
		endcase
	end
	wire range_bad = req.valid && !in_range; // [RULE8]
	guard_pkg::right_type right;
	assign right = seg_right(mode_q, seg);
	wire seg_ok = (right == guard_pkg::RIGHT_FULL) ||
		(right == guard_pkg::RIGHT_COND && cond_open_q[seg]); // [RULE4]
	wire fw_hit = fw_en_q && is_user && req.addr >= fw_lo_q &&
		req.addr <= fw_hi_q; // [RULE5]
	wire seg_bad = req.valid && !is_cr && (!seg_ok || fw_hit);
	wire cr_bad = req.valid && is_cr &&
		!cr_allowed(mode_q, cr_idx, req.write); // [RULE6] [RULE7]
	wire [guard_pkg::EV_N-1:0] ev = {cr_bad && in_range,
		seg_bad && in_range, range_bad, consist_bad};
	wire any_bad = |ev;
	wire sec_bad = consist_bad || (in_range && (seg_bad || cr_bad));

	// ****************************************************************
	// Answer and reset request
	// ****************************************************************
	logic grant_q;
	logic deny_q;
	logic rst_req_q;
	logic rst_sec_q;

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			grant_q <= 1'b0;
			deny_q <= 1'b0;
			rst_req_q <= 1'b0;
			rst_sec_q <= 1'b0;
		end else begin
			grant_q <= req.valid && !any_bad; // [RULE7]
			deny_q <= any_bad;
			rst_req_q <= any_bad; // [RULE16]
			rst_sec_q <= any_bad && sec_bad; // [RULE16]
		end
	end

	// ****************************************************************
	// Software registers
	// ****************************************************************
	wire wr_cond = reg_wr_ok && REG_ADDR_I == guard_pkg::R_COND_OPEN;
	wire wr_fwc = reg_wr_ok && REG_ADDR_I == guard_pkg::R_FW_CTRL;
	wire wr_fwl = reg_wr_ok && REG_ADDR_I == guard_pkg::R_FW_LO;
	wire wr_fwh = reg_wr_ok && REG_ADDR_I == guard_pkg::R_FW_HI;
	wire wr_clr = reg_wr_ok && REG_ADDR_I == guard_pkg::R_INT_CLR;
	wire wr_ien = reg_wr_ok && REG_ADDR_I == guard_pkg::R_INT_EN;
	wire close_all = any_bad || CORE_ERR_I; // [RULE2]
	logic [guard_pkg::EV_N-1:0] int_stat_q;
	logic [guard_pkg::EV_N-1:0] int_en_q;
	logic [guard_pkg::DATA_W-1:0] rdata_q;
	logic [guard_pkg::DATA_W-1:0] rdata_d;
	logic irq_q;

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			cond_open_q <= guard_pkg::COND_RESET; // [RULE1]
		end else if (close_all || SESSION_END_I) begin
			cond_open_q <= guard_pkg::COND_RESET; // [RULE2] [RULE15]
		end else if (wr_cond) begin
			cond_open_q <= REG_WDATA_I[3:0];
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			fw_en_q <= 1'b0;
			fw_lo_q <= guard_pkg::FW_LO_RESET;
			fw_hi_q <= guard_pkg::FW_HI_RESET;
		end else if (SESSION_END_I) begin
			fw_en_q <= 1'b0; // [RULE15]
			fw_lo_q <= guard_pkg::FW_LO_RESET;
			fw_hi_q <= guard_pkg::FW_HI_RESET;
		end else begin
			fw_en_q <= wr_fwc ? REG_WDATA_I[0] : fw_en_q;
			fw_lo_q <= wr_fwl ? REG_WDATA_I : fw_lo_q;
			fw_hi_q <= wr_fwh ? REG_WDATA_I : fw_hi_q;
		end
	end

	// New events win over a clear in the same cycle
	wire [guard_pkg::EV_N-1:0] clr_mask = wr_clr ?
		REG_WDATA_I[guard_pkg::EV_N-1:0] : '0;
	wire [guard_pkg::EV_N-1:0] stat_d = (int_stat_q & ~clr_mask) | ev;

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			int_stat_q <= '0;
			int_en_q <= '0;
			irq_q <= 1'b0;
		end else begin
			int_stat_q <= stat_d;
			int_en_q <= wr_ien ? REG_WDATA_I[guard_pkg::EV_N-1:0] : int_en_q;
			irq_q <= |(stat_d & (wr_ien ?
				REG_WDATA_I[guard_pkg::EV_N-1:0] : int_en_q));
		end
	end

	always_comb begin
		rdata_d = '0;
		if (REG_RD_I) begin
			case (REG_ADDR_I)
			guard_pkg::R_COND_OPEN: rdata_d[3:0] = cond_open_q;
			guard_pkg::R_FW_CTRL: rdata_d[0] = fw_en_q;
			guard_pkg::R_FW_LO: rdata_d = fw_lo_q;
			guard_pkg::R_FW_HI: rdata_d = fw_hi_q;
			guard_pkg::R_MODE: rdata_d[5:0] = {fuse_q, test_prog_q, mode_q};
			guard_pkg::R_INT_STAT: rdata_d[guard_pkg::EV_N-1:0] = int_stat_q;
			guard_pkg::R_INT_EN: rdata_d[guard_pkg::EV_N-1:0] = int_en_q;
			default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign ACC_GRANT_O = grant_q;
	assign ACC_DENY_O = deny_q;
	assign REG_RDATA_O = rdata_q;
	assign MODE_O = mode_q;
	assign TEST_PROG_O = test_prog_q;
	assign RST_REQ_O = rst_req_q;
	assign RST_SEC_O = rst_sec_q;
	assign IRQ_O = irq_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);

	sequence s_bad_access;
		ACC_REQ_I.valid && (^ACC_REQ_I.addr != ACC_REQ_I.apar);
	endsequence
	// A second request back to back may raise its own reset request
	sequence s_reset_pulse;
		RST_REQ_O && RST_SEC_O && ACC_DENY_O
		##1 (!RST_REQ_O || $past(ACC_REQ_I.valid));
	endsequence

	chk_parity_reset: assert property ( // [RULE9]
		s_bad_access |=> s_reset_pulse)
		else $error("parity error without security reset");
	chk_reset_pulse: assert property ( // [RULE16]
		RST_REQ_O |=> !RST_REQ_O || $past(ACC_REQ_I.valid))
		else $error("reset request held without cause");
	chk_sec_tag: assert property ( // [RULE16]
		RST_SEC_O |-> RST_REQ_O)
		else $error("security tag without request");
	chk_range_reset: assert property ( // [RULE8]
		ACC_REQ_I.valid && !in_range |=> RST_REQ_O && !ACC_GRANT_O)
		else $error("out of range access not reset");
	chk_cond_close: assert property ( // [RULE2]
		CORE_ERR_I |=> cond_open_q == 4'h0)
		else $error("grants stay open after error");
	chk_no_test_late: assert property ( // [RULE11]
		mode_q == guard_pkg::MODE_BOOT && BOOT_DONE_I && fuse_q[1]
		|=> !TEST_PROG_O)
		else $error("test program after delivery");
	chk_test_start: assert property ( // [RULE10]
		mode_q == guard_pkg::MODE_BOOT && BOOT_DONE_I && test_ok
		|=> TEST_PROG_O && MODE_O == guard_pkg::MODE_SYS)
		else $error("test program not started in system mode");
	chk_user_fuse: assert property ( // [RULE12]
		is_user && ACC_REQ_I.valid && is_cr && ACC_REQ_I.write &&
		cr_idx >= guard_pkg::CR_FUSE_BASE |=> !ACC_GRANT_O && RST_SEC_O)
		else $error("user write to fuse configuration granted");
	chk_user_rise: assert property ( // [RULE13]
		MODE_O == guard_pkg::MODE_USER |=> MODE_O == guard_pkg::MODE_USER)
		else $error("user mode left without reset");
	chk_shared_vis: assert property ( // [RULE14]
		!is_cr && seg == guard_pkg::SEG_UP && ACC_REQ_I.valid && in_range &&
		!consist_bad && !fw_hit && mode_q != guard_pkg::MODE_BOOT
		|=> ACC_GRANT_O)
		else $error("shared library access refused");
	chk_session_end: assert property ( // [RULE15]
		SESSION_END_I |=> !fw_en_q && cond_open_q == 4'h0)
		else $error("settings kept after session end");

endmodule : mode_and_access_guard
`default_nettype wire

// File: tb/core_model.sv
/*
 * Behavioural processor core that issues one access per bench command.
 * Assumes the bench raises go_i for one cycle, right after a rising edge.
 */
`default_nettype none
module core_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Command from the bench
	input wire logic go_i,
	input wire logic wr_i,
	input wire logic [guard_pkg::ADDR_W-1:0] addr_i,
	input wire logic bad_i,
	// Access toward the guard
	output var guard_pkg::acc_req_type req_o
);
	timeunit 1ns;
	timeprecision 1ps;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_o <= '0;
		end else if (go_i) begin
			req_o.valid <= 1'b1;
			req_o.write <= wr_i;
			req_o.addr <= addr_i;
			req_o.apar <= ^addr_i ^ bad_i;
		end else begin
			// Released bus must not keep showing the last address
			req_o.valid <= 1'b0;
			req_o.addr <= ~req_o.addr;
			req_o.apar <= ~req_o.apar;
		end
	end
endmodule : core_model
`default_nettype wire

// File: tb/tb_top.sv
/*
 * Self-checking bench of the mode and access guard.
 * Assumes the core model answers each command one cycle later.
 */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk, rst, f_te, f_dl, f_ap, boot_done, core_err, sess_end;
	logic go, a_wr, a_bad, reg_wr, reg_rd;
	logic grant, deny, rst_req, rst_sec, irq, test_prog;
	logic [15:0] a_addr, reg_wdata, rdata;
	logic [3:0] reg_addr;
	logic [1:0] mode;
	guard_pkg::acc_req_type acc_req;
	int miscompares = 0;
	int check_count = 0;
	localparam logic [3:0] OK = 4'h8;
	localparam logic [3:0] SEC = 4'h7;
	localparam logic [3:0] ORD = 4'h6;

	core_model core (.clk_i(mclk), .rst_i(rst), .go_i(go), .wr_i(a_wr),
		.addr_i(a_addr), .bad_i(a_bad), .req_o(acc_req));

	mode_and_access_guard dut (.MCLK_I(mclk), .RST_I(rst),
		.FUSE_TEST_EN_I(f_te), .FUSE_DELIVERED_I(f_dl),
		.FUSE_APP_PRIV_I(f_ap), .BOOT_DONE_I(boot_done),
		.CORE_ERR_I(core_err), .SESSION_END_I(sess_end),
		.ACC_REQ_I(acc_req), .ACC_GRANT_O(grant), .ACC_DENY_O(deny),
		.REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
		.REG_RD_I(reg_rd), .REG_RDATA_O(rdata), .MODE_O(mode),
		.TEST_PROG_O(test_prog), .RST_REQ_O(rst_req), .RST_SEC_O(rst_sec),
		.IRQ_O(irq));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic compare(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : compare

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_check(input logic [3:0] a, input logic [15:0] exp,
		input string what);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 compare(what, exp, rdata);
	endtask : reg_check

	task automatic access(input string what, input logic w,
		input logic [15:0] a, input logic bad, input logic [3:0] exp);
		@(posedge mclk);
		go <= 1'b1;
		a_wr <= w;
		a_addr <= a;
		a_bad <= bad;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		#1 compare(what, {12'h0, exp}, {12'h0, grant, deny, rst_req, rst_sec});
	endtask : access

	task automatic pulse_irq(input logic [15:0] exp);
		@(posedge mclk);
		#1 compare("irq", exp, {15'h0, irq});
	endtask : pulse_irq

	task automatic boot(input logic te, input logic dl, input logic ap);
		@(posedge mclk);
		rst <= 1'b1;
		f_te <= te;
		f_dl <= dl;
		f_ap <= ap;
		repeat (20) @(posedge mclk);
		#1 compare("reset mode", 16'h0003, {14'h0, mode});
		@(posedge mclk);
		rst <= 1'b0;
		reg_check(guard_pkg::R_COND_OPEN, 16'h0000, "boot cond");
		@(posedge mclk);
		boot_done <= 1'b1;
		@(posedge mclk);
		boot_done <= 1'b0;
		#1 $display("boot test done, mode %0d", mode);
	endtask : boot

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic seg_test();
		access("rom closed", 0, 16'h0000, 0, SEC);
		reg_write(guard_pkg::R_COND_OPEN, 16'h0001);
		access("rom open", 0, 16'h0100, 0, OK);
		reg_write(guard_pkg::R_COND_OPEN, 16'h0000);
		access("rom shut", 0, 16'h0100, 0, SEC);
		reg_write(guard_pkg::R_COND_OPEN, 16'h000F);
		@(posedge mclk);
		core_err <= 1'b1;
		@(posedge mclk);
		core_err <= 1'b0;
		reg_check(guard_pkg::R_COND_OPEN, 16'h0000, "cond err");
		access("sys shared", 0, 16'hC000, 0, OK);
		$display("segment test done");
	endtask : seg_test

	task automatic range_test();
		reg_write(guard_pkg::R_COND_OPEN, 16'h000F);
		access("rom limit", 0, 16'h3000, 0, ORD);
		reg_check(guard_pkg::R_COND_OPEN, 16'h0000, "cond deny");
		access("nvm limit", 1, 16'h7F00, 0, ORD);
		access("nvm last", 0, 16'h7EFF, 0, OK);
		access("ram limit", 0, 16'h8800, 0, ORD);
		access("upper limit", 0, 16'hF100, 0, ORD);
		access("parity", 0, 16'h8000, 1, SEC);
		access("parity range", 0, 16'h3000, 1, SEC);
		access("sys cr wr fuse", 1, 16'hF018, 0, SEC);
		access("sys cr wr", 1, 16'hF017, 0, OK);
		access("sys cr rd", 0, 16'hF01F, 0, OK);
		access("cr unimpl", 0, 16'hF020, 0, SEC);
		$display("range test done");
	endtask : range_test

	task automatic irq_test();
		reg_check(guard_pkg::R_INT_STAT, 16'h000F, "status");
		reg_write(guard_pkg::R_INT_EN, 16'h0002);
		pulse_irq(16'h0001);
		reg_write(guard_pkg::R_INT_CLR, 16'h0002);
		pulse_irq(16'h0000);
		reg_check(guard_pkg::R_INT_STAT, 16'h000D, "status clr");
		reg_check(guard_pkg::R_INT_CLR, 16'h0000, "clr reads");
		reg_check(4'hA, 16'h0000, "unmapped");
		access("range irq", 0, 16'h8800, 0, ORD);
		pulse_irq(16'h0001);
		reg_write(guard_pkg::R_INT_CLR, 16'h000F);
		pulse_irq(16'h0000);
		reg_check(guard_pkg::R_INT_STAT, 16'h0000, "status all");
		$display("interrupt test done");
	endtask : irq_test

	task automatic setup_fw();
		reg_write(guard_pkg::R_FW_LO, 16'h8010);
		reg_write(guard_pkg::R_FW_HI, 16'h8020);
		reg_write(guard_pkg::R_FW_CTRL, 16'h0001);
		reg_write(guard_pkg::R_COND_OPEN, 16'h0002);
		reg_check(guard_pkg::R_FW_LO, 16'h8010, "fw lo set");
		reg_check(guard_pkg::R_FW_HI, 16'h8020, "fw hi set");
	endtask : setup_fw

	task automatic reuse_test();
		setup_fw();
		@(posedge mclk);
		sess_end <= 1'b1;
		@(posedge mclk);
		sess_end <= 1'b0;
		reg_check(guard_pkg::R_FW_LO, 16'h0000, "fw lo");
		reg_check(guard_pkg::R_FW_HI, 16'h0000, "fw hi");
		reg_check(guard_pkg::R_FW_CTRL, 16'h0000, "fw ctrl");
		reg_check(guard_pkg::R_COND_OPEN, 16'h0000, "cond end");
		$display("reuse test done");
	endtask : reuse_test

	task automatic user_test();
		setup_fw();
		reg_write(guard_pkg::R_MODE, 16'h0003);
		#1 compare("sys stays", 16'h0001, {14'h0, mode});
		reg_write(guard_pkg::R_MODE, 16'h0000);
		reg_write(guard_pkg::R_MODE, 16'h0001);
		#1 compare("user mode", 16'h0000, {14'h0, mode});
		reg_write(guard_pkg::R_FW_CTRL, 16'h0000);
		reg_check(guard_pkg::R_FW_CTRL, 16'h0001, "user fw");
		access("user nvm", 0, 16'h4000, 0, OK);
		access("fw low", 0, 16'h8010, 0, SEC);
		access("fw high", 1, 16'h8020, 0, SEC);
		access("fw out", 0, 16'h8021, 0, OK);
		access("nvm shut", 0, 16'h4000, 0, SEC);
		access("user rom", 0, 16'h0000, 0, SEC);
		access("user shared", 0, 16'hEFFF, 0, OK);
		access("user cr rd", 0, 16'hF007, 0, OK);
		access("user cr rd hi", 0, 16'hF008, 0, SEC);
		access("user cr wr", 1, 16'hF003, 0, OK);
		access("user cr wr hi", 1, 16'hF004, 0, SEC);
		access("user fuse", 1, 16'hF018, 0, SEC);
		$display("user test done");
	endtask : user_test

	initial begin
		repeat (50000) @(posedge mclk);
		miscompares++;
		results();
	end

	initial begin
		rst = 1'b1;
		{f_te, f_dl, f_ap, boot_done, core_err, sess_end} = '0;
		{go, a_wr, a_bad, reg_wr, reg_rd} = '0;
		a_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_addr = 4'h0;
		boot(1, 0, 0);
		compare("test mode", 16'h0001, {14'h0, mode});
		compare("test prog", 16'h0001, {15'h0, test_prog});
		reg_check(guard_pkg::R_FW_LO, 16'h0000, "fw lo rst");
		reg_check(guard_pkg::R_INT_EN, 16'h0000, "int en rst");
		boot(1, 1, 0);
		compare("dlv mode", 16'h0000, {14'h0, mode});
		compare("dlv prog", 16'h0000, {15'h0, test_prog});
		boot(0, 0, 1);
		compare("app mode", 16'h0001, {14'h0, mode});
		reg_check(guard_pkg::R_MODE, 16'h0021, "mode reg");
		seg_test();
		range_test();
		irq_test();
		reuse_test();
		user_test();
		results();
	end
endmodule : tb_top
`default_nettype wire
